// ### core/gain_ramp.sv
// Soft gain ramp between zero and full in 32 steps
`timescale 1ns/100ps
`default_nettype none
module gain_ramp
(
   input  wire logic                                clk_i,
   input  wire logic                                rst_i,
   input  wire logic                                up_i,
   input  wire logic                                down_i,
   input  wire logic [long_power_pkg::SPEED_W-1:0]  speed_i,
   output logic      [long_power_pkg::GAIN_W-1:0]   gain_o,
   output logic                                     zero_o
);
   import long_power_pkg::*;

   ramp_state_t             st_reg, st_next;
   logic [GAIN_W-1:0]       gain_reg, gain_next;
   logic [RAMP_TICK_W-1:0]  tick_reg, tick_next;
   logic [RAMP_TICK_W-1:0]  last;
   logic                    step;

   // One step every 2^(code+8)/32 cycles
   always_comb begin
      last = (RAMP_TICK_W'(1) << (RAMP_EXP_BASE - STEP_EXP + int'(speed_i)))
             - RAMP_TICK_W'(1);
      step      = (tick_reg >= last);
      st_next   = st_reg;
      gain_next = gain_reg;
      tick_next = step ? '0 : tick_reg + RAMP_TICK_W'(1);
      unique case (st_reg)
         RAMP_LOW: begin
            tick_next = '0;
            if (up_i) st_next = RAMP_RISE;
         end
         RAMP_RISE: begin
            // A fault mid-rise turns straight round
            if (down_i) begin
               st_next   = RAMP_FALL;
               tick_next = '0;
            end else if (step) begin
               gain_next = gain_reg + 6'h01;
               if (gain_reg == GAIN_FULL - 6'h01) st_next = RAMP_HIGH;
            end
         end
         RAMP_HIGH: begin
            tick_next = '0;
            if (down_i) st_next = RAMP_FALL;
         end
         RAMP_FALL: begin
            if (step) begin
               gain_next = gain_reg - 6'h01;
               if (gain_reg == 6'h01) st_next = RAMP_LOW;
            end
         end
      endcase
   end

   // Output starts at full gain so the path is live after reset
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         st_reg   <= RAMP_HIGH;
         gain_reg <= GAIN_FULL;
         tick_reg <= '0;
      end else begin
         st_reg   <= st_next;
         gain_reg <= gain_next;
         tick_reg <= tick_next;
      end
   end

   assign gain_o = gain_reg;
   assign zero_o = (st_reg == RAMP_LOW);

   ramp_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (st_reg == RAMP_LOW) && up_i |=> (st_reg == RAMP_RISE) && (gain_reg == 6'h00))
      else $error("ramp-up did not start from zero gain");

   gain_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (gain_reg != $past(gain_reg)) |-> ($past(tick_reg) == $past(last))
         && ((gain_reg - $past(gain_reg) == 6'h01) || ($past(gain_reg) - gain_reg == 6'h01)))
      else $error("gain moved off the step interval");
endmodule : gain_ramp
`default_nettype wire

// ### core/long_avg_power_guard.sv
// Long-window average power guard with paged registers and soft ramp
//
// Our own choice: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
// How it works
// - Writing force-up bit 7 while gain is zero starts a ramp-up.
// - Bit 6 enables long-level ramp-up; it resets to one.
// - A 13-bit limit, low byte and high five bits, is compared to average.
// - Check-control bit 7 gates averaging and error detection; resets to zero.
// - Window length is 2^(9+span) PA clock periods; spans above 10 count as 10.
// - Both interpolations above one: PA period is 4 x main x DAC period.
// - Channel one, main above one: PA period is 8 x main x DAC period.
// - Any other setting: PA period is 32 DAC periods.
// - Sample power is I squared plus Q squared.
// - Only the top six bits of I and Q enter the square.
// - The average's low byte reads back from a read-only register.
// - All these registers act on the paths chosen by the page register.
// - The average's upper five bits read back from a second register.
// - A ramp takes 32 steps over 2^(code+8) DAC periods.
// - A long-window error ramps down only when the fault-down bit is set.
module long_avg_power_guard
#(
   parameter int NPATH    = 2,
   parameter int SAMPLE_W = 16
)
(
   input  wire logic                                   CLK_I,
   input  wire logic                                   SYS_RST_I,
   input  wire logic [long_power_pkg::ADDR_W-1:0]      ADDR_I,
   input  wire logic [long_power_pkg::DATA_W-1:0]      WDATA_I,
   input  wire logic                                   WR_I,
   input  wire logic                                   RD_I,
   output logic      [long_power_pkg::DATA_W-1:0]      RDATA_O,
   input  wire logic [NPATH*SAMPLE_W-1:0]              I_DATA_I,
   input  wire logic [NPATH*SAMPLE_W-1:0]              Q_DATA_I,
   input  wire logic [3:0]                             MAIN_INTERP_I,
   input  wire logic [3:0]                             CHAN_INTERP_I,
   output logic      [NPATH*long_power_pkg::GAIN_W-1:0] GAIN_O,
   output logic                                        IRQ_O
);
   import long_power_pkg::*;

   // Shared registers
   logic [7:0] page_reg, page_next;
   logic [7:0] sts_reg, sts_next;
   logic [7:0] ien_reg, ien_next;
   logic [7:0] rdata_reg, rdata_next;
   logic [7:0] clr;
   logic [7:0] set;
   logic       irq_reg, irq_next;

   // Paged registers, one byte per path
   logic [NPATH-1:0][7:0] spd_reg, spd_next;
   logic [NPATH-1:0][7:0] dwn_reg, dwn_next;
   logic [NPATH-1:0][7:0] up_reg, up_next;
   logic [NPATH-1:0][7:0] lo_reg, lo_next;
   logic [NPATH-1:0][7:0] hi_reg, hi_next;
   logic [NPATH-1:0][7:0] ctl_reg, ctl_next;

   // PA clock divider
   logic [7:0] div_reg, div_next;
   logic [7:0] period;
   logic       tick_reg, tick_next;

   // Per-path links to the averager and ramp
   logic [NPATH-1:0][LIMIT_W-1:0] result;
   logic [NPATH-1:0][GAIN_W-1:0]  gain;
   logic [NPATH-1:0]              done;
   logic [NPATH-1:0]              over;
   logic [NPATH-1:0]              zero;
   logic [NPATH-1:0]              up_go;
   logic [NPATH-1:0]              down_go;
   logic                          force_wr;
   int                            sel;

   // Register writes; paged bytes land in every selected path
   always_comb begin
      page_next = page_reg;
      ien_next  = ien_reg;
      spd_next  = spd_reg;
      dwn_next  = dwn_reg;
      up_next   = up_reg;
      lo_next   = lo_reg;
      hi_next   = hi_reg;
      ctl_next  = ctl_reg;
      if (WR_I) begin
         if (ADDR_I == PAGE_ADDR) page_next = WDATA_I;
         if (ADDR_I == IRQ_ENABLE_ADDR) ien_next = WDATA_I;
         for (int p = 0; p < NPATH; p++) begin
            if (page_reg[p]) begin
               case (ADDR_I)
                  RAMP_SPEED_ADDR: spd_next[p] = WDATA_I & SPEED_MASK;
                  RAMP_DOWN_ADDR:  dwn_next[p] = WDATA_I & DOWN_MASK;
                  RAMP_UP_ADDR:    up_next[p]  = WDATA_I;
                  LIMIT_LO_ADDR:   lo_next[p]  = WDATA_I;
                  LIMIT_HI_ADDR:   hi_next[p]  = WDATA_I & HI_MASK;
                  CHECK_CTL_ADDR:  ctl_next[p] = WDATA_I & CTL_MASK;
                  default: ;
               endcase
            end
         end
      end
   end

   // Sticky events; a new event beats a clear in the same cycle
   always_comb begin
      clr = (WR_I && (ADDR_I == IRQ_CLEAR_ADDR)) ? WDATA_I : 8'h00;
      set = 8'h00;
      for (int p = 0; p < NPATH; p++) begin
         set[p]                 = done[p] & over[p];
         set[WIN_EVENT_LSB + p] = done[p];
      end
      sts_next = (sts_reg & ~clr) | set;
      irq_next = |(sts_next & ien_next);
   end

   // Read data live only in the cycle after the strobe
   always_comb begin
      sel = 0;
      for (int p = NPATH - 1; p >= 0; p--) begin
         if (page_reg[p]) sel = p;
      end
      rdata_next = 8'h00;
      if (RD_I) begin
         case (ADDR_I)
            PAGE_ADDR:       rdata_next = page_reg;
            IRQ_STATUS_ADDR: rdata_next = sts_reg;
            IRQ_ENABLE_ADDR: rdata_next = ien_reg;
            RAMP_SPEED_ADDR: rdata_next = spd_reg[sel];
            RAMP_DOWN_ADDR:  rdata_next = dwn_reg[sel];
            RAMP_UP_ADDR:    rdata_next = up_reg[sel];
            LIMIT_LO_ADDR:   rdata_next = lo_reg[sel];
            LIMIT_HI_ADDR:   rdata_next = hi_reg[sel];
            CHECK_CTL_ADDR:  rdata_next = ctl_reg[sel];
            RESULT_LO_ADDR:  rdata_next = result[sel][7:0];
            RESULT_HI_ADDR:  rdata_next = {3'h0, result[sel][12:8]};
            default:         rdata_next = 8'h00;
         endcase
      end
   end

   // PA clock period from the interpolation pins
   always_comb begin
      if ((MAIN_INTERP_I > 4'h1) && (CHAN_INTERP_I > 4'h1)) begin
         period = 8'(PA_MULT_BOTH * int'(MAIN_INTERP_I));
      end else if ((CHAN_INTERP_I == 4'h1) && (MAIN_INTERP_I > 4'h1)) begin
         period = 8'(PA_MULT_MAIN * int'(MAIN_INTERP_I));
      end else begin
         period = 8'(PA_FIXED);
      end
      // Compare by >= so a shrinking period cannot strand the count
      tick_next = (div_reg >= period - 8'h01);
      div_next  = tick_next ? 8'h00 : div_reg + 8'h01;
   end

   // Ramp triggers per path
   always_comb begin
      force_wr = WR_I && (ADDR_I == RAMP_UP_ADDR) && WDATA_I[FORCE_UP_BIT];
      for (int p = 0; p < NPATH; p++) begin
         // Level ramp-up waits for a clean window after a fault
         up_go[p] = zero[p] & ((force_wr & page_reg[p])
                    | (up_reg[p][LEVEL_UP_BIT] & done[p] & ~over[p]));
         down_go[p] = over[p] & dwn_reg[p][FAULT_DOWN_BIT];
      end
   end

   // One averager and one ramp per converter path
   for (genvar g = 0; g < NPATH; g++) begin : g_path
      power_average u_avg (
         .clk_i    (CLK_I),
         .rst_i    (SYS_RST_I),
         .en_i     (ctl_reg[g][CHECK_EN_BIT]),
         .span_i   (ctl_reg[g][SPAN_W-1:0]),
         .tick_i   (tick_reg),
         .i_top_i  (I_DATA_I[(g+1)*SAMPLE_W-1 -: SAMPLE_TOP]),
         .q_top_i  (Q_DATA_I[(g+1)*SAMPLE_W-1 -: SAMPLE_TOP]),
         .limit_i  ({hi_reg[g][4:0], lo_reg[g]}),
         .result_o (result[g]),
         .done_o   (done[g]),
         .over_o   (over[g])
      );
      gain_ramp u_ramp (
         .clk_i   (CLK_I),
         .rst_i   (SYS_RST_I),
         .up_i    (up_go[g]),
         .down_i  (down_go[g]),
         .speed_i (spd_reg[g][SPEED_W-1:0]),
         .gain_o  (gain[g]),
         .zero_o  (zero[g])
      );
      assign GAIN_O[g*GAIN_W +: GAIN_W] = gain[g];
   end

   // Register bank and divider
   always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         page_reg  <= PAGE_RST;
         ien_reg   <= IRQ_RST;
         sts_reg   <= IRQ_RST;
         irq_reg   <= 1'b0;
         rdata_reg <= 8'h00;
         div_reg   <= 8'h00;
         tick_reg  <= 1'b0;
         for (int p = 0; p < NPATH; p++) begin
            spd_reg[p] <= SPEED_RST;
            dwn_reg[p] <= DOWN_RST;
            up_reg[p]  <= UP_RST;
            lo_reg[p]  <= LIMIT_RST;
            hi_reg[p]  <= LIMIT_RST;
            ctl_reg[p] <= CTL_RST;
         end
      end else begin
         page_reg  <= page_next;
         ien_reg   <= ien_next;
         sts_reg   <= sts_next;
         irq_reg   <= irq_next;
         rdata_reg <= rdata_next;
         div_reg   <= div_next;
         tick_reg  <= tick_next;
         spd_reg   <= spd_next;
         dwn_reg   <= dwn_next;
         up_reg    <= up_next;
         lo_reg    <= lo_next;
         hi_reg    <= hi_next;
         ctl_reg   <= ctl_next;
      end
   end

   assign RDATA_O = rdata_reg;
   assign IRQ_O   = irq_reg;

   read_idle_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      !$past(RD_I) |-> (RDATA_O == 8'h00))
      else $error("read data outside the answer cycle");

   irq_level_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      IRQ_O == (|(sts_reg & ien_reg)))
      else $error("interrupt level disagrees with status");

   error_sticky_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      done[0] && over[0] |=> sts_reg[0] && sts_reg[WIN_EVENT_LSB])
      else $error("window error not latched");

   pa_gap_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      tick_reg |=> (!tick_reg) [*7])
      else $error("PA tick faster than eight cycles");

   // Gain must still be full after a first ramp step would have landed
   fault_down_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      over[NPATH-1] && !dwn_reg[NPATH-1][FAULT_DOWN_BIT] && (gain[NPATH-1] == GAIN_FULL)
         |=> ##8 (gain[NPATH-1] == GAIN_FULL))
      else $error("ramp-down without fault enable");
endmodule : long_avg_power_guard
`default_nettype wire

// ### core/power_average.sv
// Long-window I/Q power averager with limit compare
`timescale 1ns/100ps
`default_nettype none
module power_average
#(
   parameter int CNT_W = 20,
   parameter int ACC_W = 31
)
(
   input  wire logic                                clk_i,
   input  wire logic                                rst_i,
   input  wire logic                                en_i,
   input  wire logic [long_power_pkg::SPAN_W-1:0]   span_i,
   input  wire logic                                tick_i,
   input  wire logic [long_power_pkg::SAMPLE_TOP-1:0] i_top_i,
   input  wire logic [long_power_pkg::SAMPLE_TOP-1:0] q_top_i,
   input  wire logic [long_power_pkg::LIMIT_W-1:0]  limit_i,
   output logic      [long_power_pkg::LIMIT_W-1:0]  result_o,
   output logic                                     done_o,
   output logic                                     over_o
);
   import long_power_pkg::*;

   logic signed [11:0]  i_sq;
   logic signed [11:0]  q_sq;
   logic        [11:0]  pwr;
   logic        [3:0]   span_eff;
   logic        [CNT_W-1:0] last;
   logic        [ACC_W-1:0] acc_sum;
   logic        [ACC_W-1:0] avg;
   logic        [ACC_W-1:0] acc_reg, acc_next;
   logic        [CNT_W-1:0] cnt_reg, cnt_next;
   logic        [LIMIT_W-1:0] res_reg, res_next;
   logic                    done_reg, done_next;
   logic                    over_reg, over_next;

   // Window accumulate, then average by shift and compare
   always_comb begin
      i_sq     = $signed(i_top_i) * $signed(i_top_i);
      q_sq     = $signed(q_top_i) * $signed(q_top_i);
      pwr      = $unsigned(i_sq) + $unsigned(q_sq);
      // Out-of-range spans clamp so the counter cannot overflow
      span_eff = (span_i > SPAN_MAX) ? SPAN_MAX : span_i;
      last     = (CNT_W'(1) << (AVG_EXP_BASE + int'(span_eff))) - CNT_W'(1);
      acc_sum  = acc_reg + ACC_W'(pwr);
      avg      = acc_sum >> (AVG_EXP_BASE + int'(span_eff));
      acc_next  = acc_reg;
      cnt_next  = cnt_reg;
      res_next  = res_reg;
      done_next = 1'b0;
      over_next = 1'b0;
      if (!en_i) begin
         acc_next = '0;
         cnt_next = '0;
      end else if (tick_i) begin
         if (cnt_reg == last) begin
            res_next  = LIMIT_W'(avg);
            over_next = LIMIT_W'(avg) > limit_i;
            done_next = 1'b1;
            acc_next  = '0;
            cnt_next  = '0;
         end else begin
            acc_next = acc_sum;
            cnt_next = cnt_reg + CNT_W'(1);
         end
      end
   end

   // State registers
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         acc_reg  <= '0;
         cnt_reg  <= '0;
         res_reg  <= '0;
         done_reg <= 1'b0;
         over_reg <= 1'b0;
      end else begin
         acc_reg  <= acc_next;
         cnt_reg  <= cnt_next;
         res_reg  <= res_next;
         done_reg <= done_next;
         over_reg <= over_next;
      end
   end

   assign result_o = res_reg;
   assign done_o   = done_reg;
   assign over_o   = over_reg;

   over_compare_a: assert property (@(posedge clk_i) disable iff (rst_i)
      done_reg |-> (over_reg == (res_reg > $past(limit_i))))
      else $error("error flag disagrees with limit compare");

   check_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !$past(en_i) |-> !done_reg && !over_reg)
      else $error("window ended while check disabled");
endmodule : power_average
`default_nettype wire

// ### inc/long_power_pkg.sv
// Shared constants and types for the long-window power guard
package long_power_pkg;
   // Register bus shape
   localparam int ADDR_W = 12;
   localparam int DATA_W = 8;

   // Register offsets
   localparam logic [11:0] PAGE_ADDR       = 12'h008;
   localparam logic [11:0] RAMP_SPEED_ADDR = 12'h580;
   localparam logic [11:0] RAMP_DOWN_ADDR  = 12'h581;
   localparam logic [11:0] RAMP_UP_ADDR    = 12'h582;
   localparam logic [11:0] LIMIT_LO_ADDR   = 12'h583;
   localparam logic [11:0] LIMIT_HI_ADDR   = 12'h584;
   localparam logic [11:0] CHECK_CTL_ADDR  = 12'h585;
   localparam logic [11:0] RESULT_LO_ADDR  = 12'h586;
   localparam logic [11:0] RESULT_HI_ADDR  = 12'h587;
   localparam logic [11:0] IRQ_STATUS_ADDR = 12'h5F0;
   localparam logic [11:0] IRQ_ENABLE_ADDR = 12'h5F1;
   localparam logic [11:0] IRQ_CLEAR_ADDR  = 12'h5F2;

   // Field positions and writable masks
   localparam int FORCE_UP_BIT   = 7;
   localparam int LEVEL_UP_BIT   = 6;
   localparam int FAULT_DOWN_BIT = 6;
   localparam int CHECK_EN_BIT   = 7;
   localparam int SPAN_W         = 4;
   localparam int SPEED_W        = 3;
   localparam int LIMIT_W        = 13;
   localparam int WIN_EVENT_LSB  = 4;
   localparam logic [7:0] SPEED_MASK = 8'h07;
   localparam logic [7:0] DOWN_MASK  = 8'h40;
   localparam logic [7:0] HI_MASK    = 8'h1F;
   localparam logic [7:0] CTL_MASK   = 8'h8F;

   // Values after reset
   localparam logic [7:0] PAGE_RST  = 8'h01;
   localparam logic [7:0] SPEED_RST = 8'h00;
   localparam logic [7:0] DOWN_RST  = 8'h40;
   localparam logic [7:0] UP_RST    = 8'h40;
   localparam logic [7:0] LIMIT_RST = 8'h00;
   localparam logic [7:0] CTL_RST   = 8'h00;
   localparam logic [7:0] IRQ_RST   = 8'h00;

   // Averaging and PA clock figures
   localparam int AVG_EXP_BASE     = 9;
   localparam logic [3:0] SPAN_MAX = 4'hA;
   localparam int SAMPLE_TOP       = 6;
   localparam int PA_MULT_BOTH     = 4;
   localparam int PA_MULT_MAIN     = 8;
   localparam int PA_FIXED         = 32;

   // Soft ramp figures
   localparam int RAMP_EXP_BASE    = 8;
   localparam int STEP_EXP         = 5;
   localparam int GAIN_W           = 6;
   localparam int RAMP_TICK_W      = 11;
   localparam logic [5:0] GAIN_FULL = 6'h20;

   // Ramp states, Gray coded around the cycle
   typedef enum logic [1:0] {
      RAMP_LOW  = 2'h0,
      RAMP_RISE = 2'h1,
      RAMP_HIGH = 2'h3,
      RAMP_FALL = 2'h2
   } ramp_state_t;
endpackage : long_power_pkg

// ### testbench/long_avg_power_guard_tb.sv
// Self-checking testbench for the long-window power guard
`timescale 1ns/100ps
`default_nettype none
module long_avg_power_guard_tb;
   import long_power_pkg::*;
   logic        clk;
   logic        rst;
   logic [11:0] addr;
   logic [7:0]  wdata;
   logic        wr;
   logic        rd;
   logic [7:0]  rdata;
   logic [31:0] idat;
   logic [31:0] qdat;
   logic [3:0]  main_ip;
   logic [3:0]  chan_ip;
   logic [11:0] gain;
   logic        irq;
   int          error_cnt;
   int          n_tests;

   long_avg_power_guard DUT (
      .CLK_I(clk), .SYS_RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
      .RDATA_O(rdata), .I_DATA_I(idat), .Q_DATA_I(qdat), .MAIN_INTERP_I(main_ip),
      .CHAN_INTERP_I(chan_ip), .GAIN_O(gain), .IRQ_O(irq)
   );

   // 40 MHz clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: %s seen %h wanted %h", $time, what, seen, exp);
      end
   endtask : chk

   // One-cycle write strobe
   task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg

   // Read data stands only in the cycle after the strobe
   task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp, input string what);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk({8'h00, rdata}, {8'h00, exp}, what);
   endtask : rd_chk

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : wait_cyc

   // Bounded wait, so a silent interrupt cannot hang the run
   task automatic wait_irq(output int n);
      n = 0;
      // Let the edge's register updates settle before the first look
      #1;
      while (irq !== 1'b1 && n < 40000) begin
         @(posedge clk);
         #1;
         n++;
      end
   endtask : wait_irq

   task automatic end_of_test;
      $display("comparisons %0d, mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : end_of_test

   task automatic t_reset;
      chk({4'h0, gain}, 16'h0820, "gain after reset");
      chk({15'h0, irq}, 16'h0000, "irq after reset");
      rd_chk(PAGE_ADDR, 8'h01, "page");
      rd_chk(RAMP_DOWN_ADDR, 8'h40, "fault down");
      rd_chk(RAMP_UP_ADDR, 8'h40, "ramp up ctl");
      rd_chk(LIMIT_LO_ADDR, 8'h00, "limit lo");
      rd_chk(LIMIT_HI_ADDR, 8'h00, "limit hi");
      rd_chk(CHECK_CTL_ADDR, 8'h00, "check ctl");
      rd_chk(RESULT_LO_ADDR, 8'h00, "result lo");
      rd_chk(RESULT_HI_ADDR, 8'h00, "result hi");
      rd_chk(12'h123, 8'h00, "unmapped");
   endtask : t_reset

   task automatic t_regs;
      wr_reg(LIMIT_HI_ADDR, 8'hFF);
      rd_chk(LIMIT_HI_ADDR, 8'h1F, "limit hi mask");
      wr_reg(CHECK_CTL_ADDR, 8'h7F);
      rd_chk(CHECK_CTL_ADDR, 8'h0F, "ctl mask");
      wr_reg(CHECK_CTL_ADDR, 8'h00);
      wr_reg(RESULT_LO_ADDR, 8'hAA);
      rd_chk(RESULT_LO_ADDR, 8'h00, "result ro");
      wr_reg(12'h123, 8'h5A);
      // Second path only: first path must keep its limit
      wr_reg(PAGE_ADDR, 8'h02);
      wr_reg(LIMIT_LO_ADDR, 8'h55);
      rd_chk(LIMIT_LO_ADDR, 8'h55, "page 1 limit");
      wr_reg(PAGE_ADDR, 8'h01);
      rd_chk(LIMIT_LO_ADDR, 8'h00, "page 0 limit");
      wr_reg(LIMIT_HI_ADDR, 8'h00);
   endtask : t_regs

   // Top six bits are 3 and 4, so the average is 25, above a limit of 24
   // Both paths trip; the second has its fault ramp-down switched off
   task automatic t_window;
      int n;
      wr_reg(PAGE_ADDR, 8'h02);
      wr_reg(RAMP_DOWN_ADDR, 8'hBF);
      rd_chk(RAMP_DOWN_ADDR, 8'h00, "fault down off");
      wr_reg(PAGE_ADDR, 8'h03);
      wr_reg(LIMIT_LO_ADDR, 8'h18);
      wr_reg(IRQ_ENABLE_ADDR, 8'h11);
      wr_reg(CHECK_CTL_ADDR, 8'h80);
      wait_irq(n);
      chk({15'h0, n >= 511 * 8 && n <= 512 * 8 + 6}, 16'h1, "window time");
      wr_reg(PAGE_ADDR, 8'h01);
      rd_chk(IRQ_STATUS_ADDR, 8'h33, "error and end");
      rd_chk(RESULT_LO_ADDR, 8'h19, "average lo");
      rd_chk(RESULT_HI_ADDR, 8'h00, "average hi");
      wait_cyc(300);
      chk({10'h0, gain[5:0]}, 16'h0000, "ramped down");
      chk({10'h0, gain[11:6]}, 16'h0020, "no fault down");
      // Quiet the second path for the tests that follow
      wr_reg(PAGE_ADDR, 8'h02);
      wr_reg(CHECK_CTL_ADDR, 8'h00);
      wr_reg(PAGE_ADDR, 8'h01);
   endtask : t_window

   task automatic t_ramp_up;
      int n;
      wr_reg(RAMP_UP_ADDR, 8'h00);
      wr_reg(LIMIT_LO_ADDR, 8'hFF);
      wr_reg(LIMIT_HI_ADDR, 8'h1F);
      wr_reg(IRQ_CLEAR_ADDR, 8'hFF);
      wait_irq(n);
      rd_chk(IRQ_STATUS_ADDR, 8'h10, "clean end");
      wait_cyc(300);
      chk({10'h0, gain[5:0]}, 16'h0000, "no level up");
      wr_reg(RAMP_UP_ADDR, 8'h80);
      wait_cyc(200);
      chk({15'h0, gain[5:0] == 6'h20}, 16'h0, "ramp too fast");
      wait_cyc(100);
      chk({10'h0, gain[5:0]}, 16'h0020, "forced up");
      // Masked error window: status still sets, line stays low, gain falls
      wr_reg(IRQ_ENABLE_ADDR, 8'h00);
      wr_reg(LIMIT_LO_ADDR, 8'h18);
      wr_reg(LIMIT_HI_ADDR, 8'h00);
      wr_reg(RAMP_UP_ADDR, 8'h40);
      wr_reg(IRQ_CLEAR_ADDR, 8'hFF);
      wait_cyc(4200);
      rd_chk(IRQ_STATUS_ADDR, 8'h11, "masked end");
      chk({15'h0, irq}, 16'h0000, "masked irq");
      chk({10'h0, gain[5:0]}, 16'h0000, "masked down");
      // Slower ramp; a clean window at zero gain lifts it again
      wr_reg(RAMP_SPEED_ADDR, 8'hF9);
      rd_chk(RAMP_SPEED_ADDR, 8'h01, "speed mask");
      wr_reg(LIMIT_LO_ADDR, 8'hFF);
      wr_reg(LIMIT_HI_ADDR, 8'h1F);
      wr_reg(IRQ_CLEAR_ADDR, 8'hFF);
      wr_reg(IRQ_ENABLE_ADDR, 8'h10);
      wait_irq(n);
      chk({15'h0, n < 40000}, 16'h1, "clean window");
      wait_cyc(300);
      chk({15'h0, gain[5:0] == 6'h20}, 16'h0, "slow ramp");
      wait_cyc(250);
      chk({10'h0, gain[5:0]}, 16'h0020, "level up");
      wr_reg(IRQ_CLEAR_ADDR, 8'hFF);
      rd_chk(IRQ_STATUS_ADDR, 8'h00, "cleared");
   endtask : t_ramp_up

   // PA period per interpolation setting, and a longer span
   task automatic t_pa;
      int mt[4] = '{2, 1, 3, 2};
      int ct[4] = '{1, 1, 3, 2};
      int sp[4] = '{0, 0, 0, 1};
      int pt[4] = '{16, 32, 12, 8};
      int n;
      int w;
      for (int k = 0; k < 4; k++) begin
         wr_reg(CHECK_CTL_ADDR, 8'h00);
         wr_reg(IRQ_ENABLE_ADDR, 8'h10);
         wr_reg(IRQ_CLEAR_ADDR, 8'hFF);
         @(posedge clk);
         main_ip <= 4'(mt[k]);
         chan_ip <= 4'(ct[k]);
         wr_reg(CHECK_CTL_ADDR, 8'h80 | 8'(sp[k]));
         w = (512 << sp[k]) * pt[k];
         wait_irq(n);
         chk({15'h0, n >= w - pt[k] && n <= w + 6}, 16'h1, "pa period");
      end
      wr_reg(CHECK_CTL_ADDR, 8'h00);
   endtask : t_pa

   // Main sequence
   initial begin
      error_cnt = 0;
      n_tests = 0;
      rst = 1'b1;
      addr = 12'h000;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      idat = {2{16'h0FFF}};
      qdat = {2{16'h13FF}};
      main_ip = 4'h2;
      chan_ip = 4'h2;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_regs();
      t_window();
      t_ramp_up();
      t_pa();
      end_of_test();
   end

   // Watchdog well beyond the longest expected run
   initial begin
      #(90000 * 25);
      error_cnt++;
      end_of_test();
   end
endmodule : long_avg_power_guard_tb
`default_nettype wire
